// [hdl/pld_consts.svh]
// constants of the macrocell register array: offsets, fields, resets, timing
// assumes a 50 MHz pclk and a 32-bit apb register bus
`ifndef PLD_CONSTS_SVH
`define PLD_CONSTS_SVH

`define PLD_NUM_FLOPS 20
`define PLD_NUM_CELLS 10
`define PLD_NUM_PINS 22
`define PLD_NUM_FUSES 14504
`define PLD_FUSE_AW 14

`define PLD_OFF_CTRL 12'h000
`define PLD_OFF_TYPE_SEL 12'h004
`define PLD_OFF_CLK_SEL 12'h008
`define PLD_OFF_FLOP_STATE 12'h00c
`define PLD_OFF_FUSE_ADDR 12'h010
`define PLD_OFF_FUSE_DATA 12'h014
`define PLD_OFF_STATUS 12'h018

`define PLD_CTRL_LEGACY 0
`define PLD_CTRL_KEEPER 1
`define PLD_CTRL_SECURE 2

`define PLD_RST_CTRL 3'h0
`define PLD_RST_SEL 20'h00000

`define PLD_CLK_PERIOD_NS 20
`define PLD_PUR_INTERVAL_NS 1000
`define PLD_PUR_CYCLES (`PLD_PUR_INTERVAL_NS / `PLD_CLK_PERIOD_NS)
`define PLD_PUR_CNT_W 7

`endif

// [hdl/pld_pkg.sv]
// types shared by the macrocell register array
// assumes pld_consts.svh is on the include path
`default_nettype none

package pld_pkg;
  typedef enum logic {por_hold, por_run} por_state_t;
  typedef logic [19:0] flop_vec_t;
endpackage : pld_pkg

`default_nettype wire

// [hdl/pld_macrocell_register_array.sv]
// register side of a fuse-programmable logic device with an apb config port
// assumes pin-side terms arrive asynchronously and are synchronised here
//
// Overview of operation
// - Power-up reset clears every register to low shortly after supply rise.
// - Each flip-flop is configurable on its own as D-type or T-type.
// - Each flip-flop picks its clock: private product term or clock pin.
// - Two flip-flops per output cell, twenty total, each with own terms.
// - Pins have separate input path; registers feed back; outputs own enables.
// - One shared synchronous preset sets all registers to one at clock edge.
// - Each flip-flop has its own reset term clearing it without a clock.
// - Legacy mode removes T-type, pin clocking and second-register feedback.
// - Programmed security fuse makes every fuse read back programmed at once.
// - Configuration map holds 14,504 fuses incl. signature row and keeper bit.
// - Enabled keeper holds a floating pin at its last driven level.
//
// The APB slave port and the register addresses were chosen for this implementation.
`include "pld_consts.svh"
`default_nettype none

module pld_macrocell_register_array #(
  parameter int NUM_FLOPS = `PLD_NUM_FLOPS,
  parameter int NUM_CELLS = `PLD_NUM_CELLS,
  parameter int NUM_PINS = `PLD_NUM_PINS,
  parameter int NUM_FUSES = `PLD_NUM_FUSES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // array terms from the product-term plane
  input wire pld_pkg::flop_vec_t sum_term,
  input wire pld_pkg::flop_vec_t clk_term,
  input wire pld_pkg::flop_vec_t rst_term,
  input wire logic preset_term,
  input wire logic [9:0] oe_term,
  input wire logic clk_pin,
  // logic pins
  input wire logic [21:0] pad_in,
  input wire logic [21:0] pad_driven,
  output logic [9:0] io_out,
  output logic [9:0] io_oe,
  // array side results
  output pld_pkg::flop_vec_t flop_state,
  output pld_pkg::flop_vec_t feedback,
  output logic [21:0] array_in,
  output logic por_busy
);
  import pld_pkg::*;

  localparam int SW = 2 * NUM_FLOPS + NUM_FLOPS + 2 + NUM_CELLS + 2 * NUM_PINS;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] o);
    addr_hit = (a == o);
  endfunction : addr_hit

  // two-stage synchroniser for every pin-side input
  logic [SW-1:0] sync_a_q;
  logic [SW-1:0] sync_b_q;
  wire logic [SW-1:0] async_in = {preset_term, clk_pin, rst_term, clk_term,
                                  sum_term, oe_term, pad_driven, pad_in};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_q <= '0;
      sync_b_q <= '0;
    end else begin
      sync_a_q <= async_in;
      sync_b_q <= sync_a_q;
    end
  end

  wire logic [21:0] pad_s = sync_b_q[21:0];
  wire logic [21:0] drv_s = sync_b_q[43:22];
  wire logic [9:0] oe_s = sync_b_q[53:44];
  wire flop_vec_t sum_s = sync_b_q[73:54];
  wire flop_vec_t clkt_s = sync_b_q[93:74];
  wire flop_vec_t rst_s = sync_b_q[113:94];
  wire logic clkp_s = sync_b_q[114];
  wire logic preset_s = sync_b_q[115];

  // power-up reset interval
  por_state_t por_state_q;
  por_state_t por_state_d;
  logic [`PLD_PUR_CNT_W-1:0] por_cnt_q;
  logic [`PLD_PUR_CNT_W-1:0] por_cnt_d;
  wire logic por_last = (por_cnt_q == `PLD_PUR_CNT_W'(`PLD_PUR_CYCLES - 1));

  always_comb begin
    por_state_d = por_state_q;
    por_cnt_d = por_cnt_q;
    case (por_state_q)
      por_hold: begin
        por_cnt_d = por_cnt_q + `PLD_PUR_CNT_W'(1);
        if (por_last) begin
          por_state_d = por_run;
        end
      end
      default: begin
        por_cnt_d = por_cnt_q;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_state_q <= por_hold;
      por_cnt_q <= '0;
    end else begin
      por_state_q <= por_state_d;
      por_cnt_q <= por_cnt_d;
    end
  end

  wire logic busy_w = (por_state_q == por_hold);

  // configuration registers
  logic [2:0] ctrl_q;
  flop_vec_t type_sel_q;
  flop_vec_t clk_sel_q;
  logic [`PLD_FUSE_AW-1:0] fuse_addr_q;
  logic fuse_mem [NUM_FUSES];
  wire logic legacy = ctrl_q[`PLD_CTRL_LEGACY];
  wire logic keeper_en = ctrl_q[`PLD_CTRL_KEEPER];
  wire logic secure = ctrl_q[`PLD_CTRL_SECURE];

  // apb decode
  wire logic acc = psel & penable & ~pready;
  wire logic wr = acc & pwrite;
  wire logic hit_ctrl = addr_hit(paddr, `PLD_OFF_CTRL);
  wire logic hit_type = addr_hit(paddr, `PLD_OFF_TYPE_SEL);
  wire logic hit_clk = addr_hit(paddr, `PLD_OFF_CLK_SEL);
  wire logic hit_state = addr_hit(paddr, `PLD_OFF_FLOP_STATE);
  wire logic hit_faddr = addr_hit(paddr, `PLD_OFF_FUSE_ADDR);
  wire logic hit_fdata = addr_hit(paddr, `PLD_OFF_FUSE_DATA);
  wire logic hit_stat = addr_hit(paddr, `PLD_OFF_STATUS);
  wire logic hit_any = hit_ctrl | hit_type | hit_clk | hit_state |
                       hit_faddr | hit_fdata | hit_stat;
  wire logic fuse_ok = (fuse_addr_q < `PLD_FUSE_AW'(NUM_FUSES));
  // security masks readback from the first transfer after the write that sets it
  wire logic fuse_rd = secure | (fuse_ok & fuse_mem[fuse_addr_q]);

  logic [31:0] rdata_w;
  always_comb begin
    rdata_w = 32'h0;
    if (hit_ctrl) begin
      rdata_w = {29'h0, ctrl_q};
    end else if (hit_type) begin
      rdata_w = {12'h0, type_sel_q};
    end else if (hit_clk) begin
      rdata_w = {12'h0, clk_sel_q};
    end else if (hit_state) begin
      rdata_w = {12'h0, flop_state};
    end else if (hit_faddr) begin
      rdata_w = {18'h0, fuse_addr_q};
    end else if (hit_fdata) begin
      rdata_w = {31'h0, fuse_rd};
    end else if (hit_stat) begin
      rdata_w = {31'h0, busy_w};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc;
      pslverr <= acc & ~hit_any;
      prdata <= (acc & ~pwrite) ? rdata_w : 32'h0;
    end
  end

  // security bit is one-way: only reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PLD_RST_CTRL;
      type_sel_q <= `PLD_RST_SEL;
      clk_sel_q <= `PLD_RST_SEL;
      fuse_addr_q <= '0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_q <= {pwdata[2] | secure, pwdata[1:0]};
      end
      if (wr && hit_type) begin
        type_sel_q <= pwdata[19:0];
      end
      if (wr && hit_clk) begin
        clk_sel_q <= pwdata[19:0];
      end
      if (wr && hit_faddr) begin
        fuse_addr_q <= pwdata[`PLD_FUSE_AW-1:0];
      end
    end
  end

  // fuse map, signature row and keeper bit live in it; no reset on memory
  always_ff @(posedge pclk) begin
    if (wr && hit_fdata && fuse_ok) begin
      fuse_mem[fuse_addr_q] <= pwdata[0];
    end
  end

  // flip-flop array
  flop_vec_t clk_now;
  flop_vec_t clk_prev_q;
  flop_vec_t edge_w;
  flop_vec_t flop_d;
  flop_vec_t fb_d;

  for (genvar i = 0; i < NUM_FLOPS; i++) begin : g_flop
    wire logic t_mode = type_sel_q[i] & ~legacy;
    wire logic pin_clk = clk_sel_q[i] & ~legacy;
    assign clk_now[i] = pin_clk ? clkp_s : clkt_s[i];
    assign edge_w[i] = clk_now[i] & ~clk_prev_q[i];
    always_comb begin
      if (busy_w) begin
        flop_d[i] = 1'b0;
      end else if (rst_s[i]) begin
        flop_d[i] = 1'b0;
      end else if (edge_w[i] && preset_s) begin
        flop_d[i] = 1'b1;
      end else if (edge_w[i] && t_mode) begin
        flop_d[i] = flop_state[i] ^ sum_s[i];
      end else if (edge_w[i]) begin
        flop_d[i] = sum_s[i];
      end else begin
        flop_d[i] = flop_state[i];
      end
    end
    // second register of each cell is hidden from the array in legacy mode
    assign fb_d[i] = ((i % 2) == 1 && legacy) ? 1'b0 : flop_d[i];
  end

  // cell outputs and pin inputs
  logic [9:0] io_out_d;
  logic [21:0] keep_d;
  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    assign io_out_d[c] = flop_d[2 * c];
    AST_CELL_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      io_out[c] == flop_state[2 * c])
      else $error("cell output is not its first register");
  end
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    // keeper returns the last array_in level; before any drive that is the low loaded at reset
    assign keep_d[p] = drv_s[p] ? pad_s[p] :
                       (keeper_en ? array_in[p] : 1'b0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flop_state <= '0;
      feedback <= '0;
      clk_prev_q <= '0;
      io_out <= '0;
      io_oe <= '0;
      array_in <= '0;
      por_busy <= 1'b1;
    end else begin
      flop_state <= flop_d;
      feedback <= fb_d;
      clk_prev_q <= clk_now;
      io_out <= io_out_d;
      io_oe <= oe_s;
      array_in <= keep_d;
      por_busy <= (por_state_d == por_hold);
    end
  end

  // own cycle count since reset release, kept apart from the interval logic
  logic [`PLD_PUR_CNT_W-1:0] up_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt_q <= '0;
    end else if (up_cnt_q != '1) begin
      up_cnt_q <= up_cnt_q + `PLD_PUR_CNT_W'(1);
    end
  end

  // checks
  AST_POR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    busy_w |=> (flop_state == '0))
    else $error("register not clear during power-up reset");
  AST_POR_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    por_busy == (up_cnt_q < `PLD_PUR_CNT_W'(`PLD_PUR_CYCLES)))
    else $error("power-up reset interval has the wrong length");
  AST_T_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    (!busy_w && edge_w[1] && type_sel_q[1] && !legacy && sum_s[1] &&
     !rst_s[1] && !preset_s) |=> (flop_state[1] != $past(flop_state[1])))
    else $error("t-type register did not toggle");
  AST_D_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (!busy_w && edge_w[0] && (!type_sel_q[0] || legacy) && !rst_s[0] &&
     !preset_s) |=> (flop_state[0] == $past(sum_s[0])))
    else $error("d-type register did not load sum term");
  AST_NO_EDGE_HOLD: assert property (@(posedge pclk)
    disable iff (!presetn)
    (!busy_w && !edge_w[2] && !rst_s[2]) |=> $stable(flop_state[2]))
    else $error("register changed without its clock");
  AST_PRESET: assert property (@(posedge pclk) disable iff (!presetn)
    (!busy_w && preset_s && edge_w[3] && !rst_s[3]) |=> flop_state[3])
    else $error("preset did not set register");
  AST_ARST_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    (rst_s != '0) |=> ((flop_state & $past(rst_s)) == '0))
    else $error("reset term did not clear register");
  AST_LEGACY_FB: assert property (@(posedge pclk) disable iff (!presetn)
    legacy |=> ((feedback & 20'haaaaa) == '0))
    else $error("second register fed back in legacy mode");
  AST_SECURE_RD: assert property (@(posedge pclk) disable iff (!presetn)
    (secure && acc && !pwrite && hit_fdata) |=> prdata[0])
    else $error("fuse readback not masked");
  AST_SEC_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    secure |=> secure)
    else $error("security bit cleared without reset");
  AST_KEEPER: assert property (@(posedge pclk) disable iff (!presetn)
    (keeper_en && !drv_s[4]) |=> (array_in[4] == $past(array_in[4])))
    else $error("keeper lost pin level");
  AST_OE: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (io_oe == $past(oe_s)))
    else $error("output enable does not follow its term");
  COV_TOGGLE: cover property (@(posedge pclk) disable iff (!presetn)
    edge_w[1] && type_sel_q[1] && sum_s[1] && !busy_w);
  COV_PRESET: cover property (@(posedge pclk) disable iff (!presetn)
    preset_s && edge_w != '0 && !busy_w);
  COV_SECURE: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(secure));
  COV_ARST_PRESET: cover property (@(posedge pclk) disable iff (!presetn)
    preset_s && rst_s[0] && edge_w[0]);

endmodule : pld_macrocell_register_array

`default_nettype wire

// [dv/board_drv.sv]
// board-side model: drives clock terms, clock pin and preset term
// assumes pulse is called just after a rising pclk edge
`default_nettype none

module board_drv (
  // clock
  input wire logic pclk,
  // terms into the array
  output pld_pkg::flop_vec_t clk_term,
  output logic clk_pin,
  output logic preset_term
);
  timeunit 1ns;
  timeprecision 1ns;
  import pld_pkg::*;

  // clocks stand still until the bench asks for a pulse
  initial begin
    clk_term = '0;
    clk_pin = 1'b0;
    preset_term = 1'b0;
  end

  // four cycles a phase, clear of the two-flop sync
  task automatic pulse(input flop_vec_t m, input logic p, input logic s);
    preset_term <= s;
    @(posedge pclk);
    clk_term <= m;
    clk_pin <= p;
    repeat (4) @(posedge pclk);
    clk_term <= '0;
    clk_pin <= 1'b0;
    preset_term <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse
endmodule : board_drv

`default_nettype wire

// [dv/test_pld_macrocell_register_array.sv]
// self-checking bench for the macrocell register array
// assumes board_drv makes clock terms; apb slave answers in a few cycles
`include "pld_consts.svh"
`default_nettype none

module test_pld_macrocell_register_array;
  timeunit 1ns;
  timeprecision 1ns;
  import pld_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, clk_pin, preset_term, por_busy;
  flop_vec_t sum_term = '0;
  flop_vec_t rst_term = '0;
  flop_vec_t clk_term, flop_state, feedback;
  logic [9:0] oe_term = 10'h000;
  logic [9:0] io_out, io_oe;
  logic [21:0] pad_in = 22'h0;
  logic [21:0] pad_driven = 22'h3fffff;
  logic [21:0] array_in;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;

  always #10 pclk = ~pclk;

  board_drv drv (.pclk, .clk_term, .clk_pin, .preset_term);

  pld_macrocell_register_array dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sum_term, .clk_term, .rst_term,
    .preset_term, .oe_term, .clk_pin, .pad_in, .pad_driven, .io_out,
    .io_oe, .flop_state, .feedback, .array_in, .por_busy
  );

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // one transfer; the wait ends on pready, bounded against a hang
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 16) begin
      @(posedge pclk);
      k++;
    end
    if (k == 16) chk(pready, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb

  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    chk(flop_state, 32'h0);
    chk(por_busy, 32'h1);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `PLD_OFF_STATUS, 32'h0);
    chk(rd, 32'h1);
    repeat (60) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h01c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // d-type then t-type, product-term and pin clocks, reset term and preset
    sum_term <= 20'h00003;
    drv.pulse(20'hfffff, 1'b0, 1'b0);
    chk(flop_state, 32'h3);
    chk(io_out, 32'h1);
    apb(1'b1, `PLD_OFF_TYPE_SEL, 32'hf);
    apb(1'b1, `PLD_OFF_CLK_SEL, 32'hc);
    sum_term <= 20'h0000a;
    drv.pulse(20'h00003, 1'b1, 1'b0);
    chk(flop_state, 32'h9);
    drv.pulse(20'h00000, 1'b1, 1'b0);
    chk(flop_state, 32'h1);
    apb(1'b0, `PLD_OFF_FLOP_STATE, 32'h0);
    chk(rd, 32'h1);
    rst_term <= 20'h00001;
    repeat (4) @(posedge pclk);
    chk(flop_state, 32'h0);
    rst_term <= 20'h00001;
    drv.pulse(20'hfffff, 1'b1, 1'b1);
    chk(flop_state, 32'hffffe);
    rst_term <= 20'h00000;
    chk(feedback, 32'hffffe);
    chk(io_out, 32'h3fe);
    // legacy: d-type, term clocks, odd feedback off
    apb(1'b1, `PLD_OFF_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk(feedback, 32'h55554);
    sum_term <= 20'h00004;
    drv.pulse(20'hfffff, 1'b0, 1'b0);
    chk(flop_state, 32'h4);
    oe_term <= 10'h2a5;
    pad_in <= 22'h2a5a5;
    apb(1'b1, `PLD_OFF_CTRL, 32'h2);
    repeat (4) @(posedge pclk);
    chk(io_oe, 32'h2a5);
    chk(array_in, 32'h2a5a5);
    // released pins show the inverse level, keeper must hide it
    pad_driven <= 22'h0;
    pad_in <= ~22'h2a5a5;
    repeat (4) @(posedge pclk);
    chk(array_in, 32'h2a5a5);
    apb(1'b1, `PLD_OFF_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk(array_in, 32'h0);
    apb(1'b1, `PLD_OFF_FUSE_ADDR, 32'h38a7);
    apb(1'b1, `PLD_OFF_FUSE_DATA, 32'h0);
    apb(1'b0, `PLD_OFF_FUSE_DATA, 32'h0);
    chk(rd[0], 32'h0);
    apb(1'b1, `PLD_OFF_CTRL, 32'h4);
    apb(1'b0, `PLD_OFF_FUSE_DATA, 32'h0);
    chk(rd[0], 32'h1);
    apb(1'b1, `PLD_OFF_CTRL, 32'h0);
    apb(1'b0, `PLD_OFF_CTRL, 32'h0);
    chk(rd, 32'h4);
    test_done();
  end
endmodule : test_pld_macrocell_register_array

`default_nettype wire
